// *** inc/dtc_pkg.sv ***
// Package for the DAC trim and calibration configuration bank.
// Assumes a single 125 MHz clock domain and an I2C control port.
package dtc_pkg;

  // ==========================================================
  // Control port identity and page
  // ==========================================================
  localparam logic [6:0] DTC_DEV_ADDR_DFLT = 7'h2a; // Arbitrary value
  localparam logic [7:0] DTC_PAGE_SEL_OFF  = 8'h00; // Page select register
  localparam logic [7:0] DTC_PAGE_NUM      = 8'hfd; // Page holding the bank
  localparam logic [7:0] DTC_PAGE_RST      = 8'h00;

  // ==========================================================
  // Register offsets
  // ==========================================================
  localparam int         DTC_NUM_REGS            = 7;
  localparam logic [7:0] DTC_OFFSET_CAL_FILTER_CTRL  = 8'h0b;
  localparam logic [7:0] DTC_DITHER_BOND_B_CTRL      = 8'h0c;
  localparam logic [7:0] DTC_DITHER_BOND_C_CTRL      = 8'h0d;
  localparam logic [7:0] DTC_SPEEDUP_CTRL            = 8'h0e;
  localparam logic [7:0] DTC_SHORT_DETECT_OFFSET_CTRL = 8'h0f;
  localparam logic [7:0] DTC_SHUFFLE_DITHER_POL_CTRL = 8'h10;
  localparam logic [7:0] DTC_DAC_SCALE_CTRL          = 8'h11;

  // Bank entry indices, offset minus the first offset
  localparam int DTC_IDX_CAL   = 0;
  localparam int DTC_IDX_DB    = 1;
  localparam int DTC_IDX_DC    = 2;
  localparam int DTC_IDX_SPD   = 3;
  localparam int DTC_IDX_SHORT = 4;
  localparam int DTC_IDX_SHUF  = 5;
  localparam int DTC_IDX_SCALE = 6;

  // ==========================================================
  // Reset values, entry 6 first
  // ==========================================================
  localparam logic [DTC_NUM_REGS-1:0][7:0] DTC_CFG_RST =
    {8'h00, 8'h20, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int DTC_DITHER_BIT      = 7;
  localparam int DTC_CAL_BYPASS_BIT  = 4;
  localparam int DTC_CAL_FULL_BIT    = 3;
  localparam int DTC_CAL_AVG_BIT     = 2;
  localparam int DTC_CAL_FINE_BIT    = 1;
  localparam int DTC_CAL_POST_BIT    = 0;
  localparam int DTC_CLK_MISS_BIT    = 4;
  localparam int DTC_ANA_SEQ_BIT     = 0;
  localparam int DTC_SHORT_OFF_BIT   = 4;
  localparam int DTC_LATER_OFS_BIT   = 0;
  localparam int DTC_SHUF_LSB        = 4;
  localparam int DTC_SEC_SIGN_BIT    = 0;
  localparam int DTC_LEFT_SCALE_BIT  = 7;
  localparam int DTC_RIGHT_SCALE_BIT = 3;

  // ==========================================================
  // Calibration step counts and shuffle codes
  // ==========================================================
  localparam logic [6:0] DTC_COARSE_STEPS_FINE = 7'd64;
  localparam logic [6:0] DTC_COARSE_STEPS_ONLY = 7'd96;
  localparam logic [5:0] DTC_FINE_STEPS        = 6'd32;
  localparam logic [5:0] DTC_FINE_STEPS_NONE   = 6'd0;
  localparam logic [1:0] DTC_SHUF_INTERNAL     = 2'h1;
  localparam logic [1:0] DTC_SHUF_GLOBAL       = 2'h2;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    DTC_BOND_RESERVED = 2'h0,
    DTC_BOND_MID      = 2'h1,
    DTC_BOND_HIGH     = 2'h2,
    DTC_BOND_NONE     = 2'h3
  } dtc_bond_t;

  typedef enum logic [2:0] {
    DTC_ST_IDLE, DTC_ST_ADDR, DTC_ST_SUB, DTC_ST_WR, DTC_ST_ACK, DTC_ST_RD, DTC_ST_RACK
  } dtc_i2c_st_t;

endpackage

// *** inc/dtc_reg_if.sv ***
// Register access carrier between the control port and the bank.
// Assumes both ends sit on the same clock.
`timescale 1ns/100ps
interface dtc_reg_if;
  import dtc_pkg::*;

  // ==========================================================
  // Access and register images
  // ==========================================================
  logic [7:0]                   addr;
  logic [7:0]                   wdata;
  logic                         wr;
  logic [7:0]                   rdata;
  logic [DTC_NUM_REGS-1:0][7:0] cfg;

  modport master (output addr, output wdata, output wr, input rdata, input cfg);
  modport bank   (input addr, input wdata, input wr, output rdata, output cfg);
endinterface

// *** logic/dtc_reg_bank.sv ***
// Paged storage for the seven configuration registers plus page select.
// Assumes one-cycle write strobes from the control port.
`timescale 1ns/100ps
module dtc_reg_bank
  import dtc_pkg::*;
(
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_arst_n,
  // Register access
  dtc_reg_if.bank   rif
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [7:0]                   page;
    logic [DTC_NUM_REGS-1:0][7:0] cfg;
  } dtc_bank_t;

  dtc_bank_t             bank_r;
  dtc_bank_t             bank_nxt;
  logic [DTC_NUM_REGS-1:0] hit;
  logic                  page_ok;

  assign page_ok = (bank_r.page == DTC_PAGE_NUM);

  // Per-entry address match on the bank page
  for (genvar i = 0; i < DTC_NUM_REGS; i++) begin : g_hit
    assign hit[i] = page_ok && (rif.addr == DTC_OFFSET_CAL_FILTER_CTRL + 8'(i));
  end

  // Writes and read mux; unmapped reads return zero
  always_comb begin
    bank_nxt  = bank_r;
    rif.rdata = 8'h00;
    if (rif.addr == DTC_PAGE_SEL_OFF) begin
      rif.rdata = bank_r.page;
      if (rif.wr) begin
        bank_nxt.page = rif.wdata;
      end
    end
    for (int i = 0; i < DTC_NUM_REGS; i++) begin
      if (hit[i]) begin
        rif.rdata = bank_r.cfg[i];
        if (rif.wr) begin
          bank_nxt.cfg[i] = rif.wdata;
        end
      end
    end
  end

  // Register the bank
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bank_r <= '{page: DTC_PAGE_RST, cfg: DTC_CFG_RST};
    end else begin
      bank_r <= bank_nxt;
    end
  end

  assign rif.cfg = bank_r.cfg;

endmodule

// *** logic/dtc_trim_cfg.sv ***
// DAC trim and calibration configuration: I2C slave plus control decode.
// Assumes SCL and SDA already synchronous to i_sys_clk; SDA is open drain.
//
// Operation
// - Bypass bit set skips the calibration front-end filter, clear uses it.
// - Full-span clear runs filter in last half period, set whole period.
// - Filter-type bit picks majority decision at zero, averaging at one.
// - Fine disable clear: 64 coarse plus 32 fine steps; set: 96 coarse only.
// - Post-average disable picks integrator output instead of averaged result.
// - Three dither bits each act only under their matching bond option.
// - Two speed-up bits for clock-missing detection and analog sequence, reset zero.
// - Short detection control is inverted and resets to disabled.
// - Later offset cancellation disable bit resets clear, cancellation enabled.
// - Shuffle field: 0 and 3 none, 1 internal, 2 global.
// - One bit selects positive or negative four percent secondary dither.
// - Two bits set left and right secondary-to-primary scaling.
`timescale 1ns/100ps
module dtc_trim_cfg
  import dtc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DTC_DEV_ADDR_DFLT
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  // I2C control port
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_out,
  output logic            o_sda_oe_n,
  // Bond option of the part
  input  wire logic [1:0] i_bond_sel,
  // Offset calibration controls
  output logic            o_cal_filter_bypass,
  output logic            o_cal_filter_full_span,
  output logic            o_cal_filter_averaging,
  output logic            o_cal_fine_disable,
  output logic [6:0]      o_cal_coarse_steps,
  output logic [5:0]      o_cal_fine_steps,
  output logic            o_cal_post_avg_disable,
  // Dither and bond controls
  output logic            o_dither_reserved_bond,
  output logic            o_dither_bond_mid,
  output logic            o_dither_bond_high,
  output logic            o_dither_adjust,
  output logic            o_secondary_dither_sign,
  // Speed-up and protection controls
  output logic            o_clk_missing_speedup,
  output logic            o_analog_seq_speedup,
  output logic            o_short_detect_off_n,
  output logic            o_short_detect_en,
  output logic            o_later_offset_cancel_off,
  // DWA shuffle and scaling
  output logic [1:0]      o_dwa_shuffle_sel,
  output logic            o_dwa_shuffle_internal,
  output logic            o_dwa_shuffle_global,
  output logic            o_left_sec_scale,
  output logic            o_right_sec_scale
);

  // ==========================================================
  // Register bank
  // ==========================================================
  dtc_reg_if rif ();

  dtc_reg_bank u_bank (
    .i_sys_clk (i_sys_clk),
    .i_arst_n  (i_arst_n),
    .rif       (rif)
  );

  // ==========================================================
  // I2C slave state
  // ==========================================================
  typedef struct packed {
    dtc_i2c_st_t st;
    dtc_i2c_st_t after;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic [7:0]  ptr;
    logic        drive;
    logic        acked;
    logic        scl_q;
    logic        sda_q;
  } dtc_i2c_t;

  dtc_i2c_t   i2c_r;
  dtc_i2c_t   i2c_nxt;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic       byte_done;
  logic       wr_stb;

  // Bus conditions seen against the previous sample
  assign scl_rise   = i_scl && !i2c_r.scl_q;
  assign scl_fall   = !i_scl && i2c_r.scl_q;
  assign start_cond = i_scl && i2c_r.scl_q && i2c_r.sda_q && !i_sda;
  assign stop_cond  = i_scl && i2c_r.scl_q && !i2c_r.sda_q && i_sda;
  assign byte_done  = scl_fall && (i2c_r.cnt == 4'd8);

  // Next state of the slave
  always_comb begin
    i2c_nxt       = i2c_r;
    i2c_nxt.scl_q = i_scl;
    i2c_nxt.sda_q = i_sda;
    wr_stb        = 1'b0;
    if (start_cond) begin
      i2c_nxt.st    = DTC_ST_ADDR;
      i2c_nxt.cnt   = 4'd0;
      i2c_nxt.drive = 1'b0;
    end else if (stop_cond) begin
      i2c_nxt.st    = DTC_ST_IDLE;
      i2c_nxt.drive = 1'b0;
    end else begin
      unique case (i2c_r.st)
        DTC_ST_IDLE: begin
          i2c_nxt.drive = 1'b0;
        end
        DTC_ST_ADDR, DTC_ST_SUB, DTC_ST_WR: begin
          // Shift in on rising SCL, act on the falling edge after bit 8
          if (scl_rise) begin
            i2c_nxt.shreg = {i2c_r.shreg[6:0], i_sda};
            i2c_nxt.cnt   = i2c_r.cnt + 4'd1;
          end
          if (byte_done) begin
            i2c_nxt.cnt   = 4'd0;
            i2c_nxt.drive = 1'b1;
            i2c_nxt.st    = DTC_ST_ACK;
            i2c_nxt.after = DTC_ST_WR;
            if (i2c_r.st == DTC_ST_ADDR) begin
              if (i2c_r.shreg[7:1] != DEV_ADDR) begin
                i2c_nxt.drive = 1'b0;
                i2c_nxt.st    = DTC_ST_IDLE;
              end else if (i2c_r.shreg[0]) begin
                i2c_nxt.after = DTC_ST_RD;
                i2c_nxt.shreg = rif.rdata;
                i2c_nxt.ptr   = i2c_r.ptr + 8'd1;
              end else begin
                i2c_nxt.after = DTC_ST_SUB;
              end
            end else if (i2c_r.st == DTC_ST_SUB) begin
              i2c_nxt.ptr = i2c_r.shreg;
            end else begin
              wr_stb      = 1'b1;
              i2c_nxt.ptr = i2c_r.ptr + 8'd1;
            end
          end
        end
        DTC_ST_ACK: begin
          // Release after the acknowledge clock, or present the first read bit
          if (scl_fall) begin
            i2c_nxt.st    = i2c_r.after;
            i2c_nxt.drive = 1'b0;
            i2c_nxt.cnt   = 4'd0;
            if (i2c_r.after == DTC_ST_RD) begin
              i2c_nxt.drive = !i2c_r.shreg[7];
              i2c_nxt.cnt   = 4'd1;
            end
          end
        end
        DTC_ST_RD: begin
          // Next data bit on each falling SCL
          if (scl_fall) begin
            if (i2c_r.cnt == 4'd8) begin
              i2c_nxt.st    = DTC_ST_RACK;
              i2c_nxt.drive = 1'b0;
              i2c_nxt.cnt   = 4'd0;
            end else begin
              i2c_nxt.shreg = {i2c_r.shreg[6:0], 1'b0};
              i2c_nxt.drive = !i2c_r.shreg[6];
              i2c_nxt.cnt   = i2c_r.cnt + 4'd1;
            end
          end
        end
        DTC_ST_RACK: begin
          // Master acknowledge fetches the next byte, a nack ends the read
          if (scl_rise) begin
            i2c_nxt.acked = !i_sda;
            if (!i_sda) begin
              i2c_nxt.shreg = rif.rdata;
              i2c_nxt.ptr   = i2c_r.ptr + 8'd1;
            end
          end
          if (scl_fall) begin
            i2c_nxt.st    = i2c_r.acked ? DTC_ST_RD : DTC_ST_IDLE;
            i2c_nxt.drive = i2c_r.acked && !i2c_r.shreg[7];
            i2c_nxt.cnt   = 4'd1;
          end
        end
      endcase
    end
  end

  // Register the slave state
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      i2c_r <= '{st: DTC_ST_IDLE, after: DTC_ST_IDLE, cnt: 4'h0, shreg: 8'h00,
                 ptr: 8'h00, drive: 1'b0, acked: 1'b0, scl_q: 1'b1, sda_q: 1'b1};
    end else begin
      i2c_r <= i2c_nxt;
    end
  end

  // Bank access at the current pointer
  assign rif.addr  = i2c_r.ptr;
  assign rif.wdata = i2c_r.shreg;
  assign rif.wr    = wr_stb;

  // Open-drain pin: only ever pulls low
  assign o_sda_out  = 1'b0;
  assign o_sda_oe_n = !i2c_r.drive;

  // ==========================================================
  // Offset calibration controls
  // ==========================================================
  assign o_cal_filter_bypass    = rif.cfg[DTC_IDX_CAL][DTC_CAL_BYPASS_BIT];
  assign o_cal_filter_full_span = rif.cfg[DTC_IDX_CAL][DTC_CAL_FULL_BIT];
  assign o_cal_filter_averaging = rif.cfg[DTC_IDX_CAL][DTC_CAL_AVG_BIT];
  assign o_cal_fine_disable     = rif.cfg[DTC_IDX_CAL][DTC_CAL_FINE_BIT];
  assign o_cal_post_avg_disable = rif.cfg[DTC_IDX_CAL][DTC_CAL_POST_BIT];

  // Step counts of the calibration sequence
  assign o_cal_coarse_steps = o_cal_fine_disable ? DTC_COARSE_STEPS_ONLY : DTC_COARSE_STEPS_FINE;
  assign o_cal_fine_steps   = o_cal_fine_disable ? DTC_FINE_STEPS_NONE : DTC_FINE_STEPS;

  // ==========================================================
  // Dither controls
  // ==========================================================
  assign o_dither_reserved_bond  = rif.cfg[DTC_IDX_CAL][DTC_DITHER_BIT];
  assign o_dither_bond_mid       = rif.cfg[DTC_IDX_DB][DTC_DITHER_BIT];
  assign o_dither_bond_high      = rif.cfg[DTC_IDX_DC][DTC_DITHER_BIT];
  assign o_secondary_dither_sign = rif.cfg[DTC_IDX_SHUF][DTC_SEC_SIGN_BIT];

  // Only the setting of the fitted bond option reaches the modulator
  always_comb begin
    unique case (dtc_bond_t'(i_bond_sel))
      DTC_BOND_RESERVED: o_dither_adjust = o_dither_reserved_bond;
      DTC_BOND_MID:      o_dither_adjust = o_dither_bond_mid;
      DTC_BOND_HIGH:     o_dither_adjust = o_dither_bond_high;
      DTC_BOND_NONE:     o_dither_adjust = 1'b0;
    endcase
  end

  // ==========================================================
  // Speed-up and protection controls
  // ==========================================================
  assign o_clk_missing_speedup     = rif.cfg[DTC_IDX_SPD][DTC_CLK_MISS_BIT];
  assign o_analog_seq_speedup      = rif.cfg[DTC_IDX_SPD][DTC_ANA_SEQ_BIT];
  assign o_short_detect_off_n      = rif.cfg[DTC_IDX_SHORT][DTC_SHORT_OFF_BIT];
  assign o_short_detect_en         = !o_short_detect_off_n;
  assign o_later_offset_cancel_off = rif.cfg[DTC_IDX_SHORT][DTC_LATER_OFS_BIT];

  // ==========================================================
  // DWA shuffle and scaling
  // ==========================================================
  assign o_dwa_shuffle_sel      = rif.cfg[DTC_IDX_SHUF][DTC_SHUF_LSB+1:DTC_SHUF_LSB];
  assign o_dwa_shuffle_internal = (o_dwa_shuffle_sel == DTC_SHUF_INTERNAL);
  assign o_dwa_shuffle_global   = (o_dwa_shuffle_sel == DTC_SHUF_GLOBAL);
  assign o_left_sec_scale       = rif.cfg[DTC_IDX_SCALE][DTC_LEFT_SCALE_BIT];
  assign o_right_sec_scale      = rif.cfg[DTC_IDX_SCALE][DTC_RIGHT_SCALE_BIT];

endmodule

// *** bench/dtc_trim_cfg_chk.sv ***
// Concurrent checks on the config bank top ports.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/100ps
module dtc_trim_cfg_chk
  import dtc_pkg::*;
(
  // Clock, reset and inputs
  input wire logic       i_sys_clk,
  input wire logic       i_arst_n,
  input wire logic       i_scl,
  input wire logic [1:0] i_bond_sel,
  // Watched outputs
  input wire logic       o_cal_filter_bypass,
  input wire logic       o_cal_fine_disable,
  input wire logic [6:0] o_cal_coarse_steps,
  input wire logic [5:0] o_cal_fine_steps,
  input wire logic       o_dither_reserved_bond,
  input wire logic       o_dither_bond_mid,
  input wire logic       o_dither_bond_high,
  input wire logic       o_dither_adjust,
  input wire logic       o_secondary_dither_sign,
  input wire logic       o_clk_missing_speedup,
  input wire logic       o_short_detect_off_n,
  input wire logic       o_short_detect_en,
  input wire logic       o_later_offset_cancel_off,
  input wire logic [1:0] o_dwa_shuffle_sel,
  input wire logic       o_dwa_shuffle_internal,
  input wire logic       o_dwa_shuffle_global,
  input wire logic       o_left_sec_scale,
  input wire logic       o_right_sec_scale
);
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  // Dither bit picked by the bond option
  logic dith_exp;
  assign dith_exp = i_bond_sel == 2'h0 ? o_dither_reserved_bond : i_bond_sel == 2'h1 ? o_dither_bond_mid :
                    i_bond_sel == 2'h2 ? o_dither_bond_high : 1'b0;
  AST_SHORT_INV: assert property (o_short_detect_en == !o_short_detect_off_n)
    else $error("short detect enable not inverse of its control bit");
  AST_FINE_OFF: assert property (o_cal_fine_disable |-> o_cal_coarse_steps == 7'd96 && o_cal_fine_steps == 6'd0)
    else $error("step counts wrong with fine calibration off");
  AST_FINE_ON: assert property (!o_cal_fine_disable |-> o_cal_coarse_steps == 7'd64 && o_cal_fine_steps == 6'd32)
    else $error("step counts wrong with fine calibration on");
  AST_SHUF_INT: assert property (o_dwa_shuffle_internal == (o_dwa_shuffle_sel == 2'h1))
    else $error("internal shuffle decode wrong");
  AST_SHUF_GLB: assert property (o_dwa_shuffle_global == (o_dwa_shuffle_sel == 2'h2))
    else $error("global shuffle decode wrong");
  AST_DITHER_SEL: assert property (o_dither_adjust == dith_exp)
    else $error("dither adjust not from selected bond bit");
  AST_RST_DFLT: assert property ($rose(i_arst_n) |-> o_short_detect_off_n && o_dwa_shuffle_sel == 2'h2 &&
    !o_clk_missing_speedup && !o_later_offset_cancel_off) else $error("defaults wrong after reset");
  AST_CAL_HOLD: assert property (i_scl && $past(i_scl) |-> $stable({o_cal_filter_bypass, o_cal_fine_disable}))
    else $error("calibration control moved while clock line high");
  AST_SCALE_HOLD: assert property (i_scl && $past(i_scl) |-> $stable({o_left_sec_scale, o_right_sec_scale}))
    else $error("scale control moved while clock line high");
  // Main scenarios reached
  CV_FINE_OFF: cover property (o_cal_fine_disable);
  CV_SHUF_INT: cover property (o_dwa_shuffle_internal);
  CV_DITHER: cover property (o_dither_adjust && o_secondary_dither_sign);
endmodule

bind dtc_trim_cfg dtc_trim_cfg_chk u_chk (.i_sys_clk, .i_arst_n, .i_scl, .i_bond_sel, .o_cal_filter_bypass,
  .o_cal_fine_disable, .o_cal_coarse_steps, .o_cal_fine_steps, .o_dither_reserved_bond, .o_dither_bond_mid,
  .o_dither_bond_high, .o_dither_adjust, .o_secondary_dither_sign, .o_clk_missing_speedup, .o_short_detect_off_n,
  .o_short_detect_en, .o_later_offset_cancel_off, .o_dwa_shuffle_sel, .o_dwa_shuffle_internal,
  .o_dwa_shuffle_global, .o_left_sec_scale, .o_right_sec_scale);

// *** bench/dtc_i2c_host.sv ***
// Host model driving the I2C control port.
// Assumes the bench resolves the open-drain data wire.
`timescale 1ns/100ps
module dtc_i2c_host (
  // Clock and bus
  input  wire logic i_sys_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda,
  // Read results
  output logic       o_rd_vld,
  output logic [7:0] o_rd_byte
);
  // ==========================================================
  // Bus phases, four clocks each
  // ==========================================================
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
    o_rd_vld = 1'b0;
    o_rd_byte = 8'h00;
  end
  task automatic ph(input logic s, input logic d);
    @(posedge i_sys_clk);
    o_scl <= s;
    o_sda <= d;
    o_rd_vld <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask
  task automatic start();
    ph(1'b1, 1'b1); ph(1'b1, 1'b0); ph(1'b0, 1'b0);
  endtask
  task automatic rstart();
    ph(1'b0, 1'b1); start();
  endtask
  task automatic stop();
    ph(1'b0, 1'b0); ph(1'b1, 1'b0); ph(1'b1, 1'b1);
  endtask
  // Byte out, data moves only while clock low
  task automatic wr(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      ph(1'b0, b[i]); ph(1'b1, b[i]); ph(1'b0, b[i]);
    end
    ph(1'b0, 1'b1); ph(1'b1, 1'b1);
    ack = !i_sda;
    ph(1'b0, 1'b1);
  endtask
  // Byte in, acknowledged unless last
  task automatic rd(input logic last);
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      ph(1'b0, 1'b1); ph(1'b1, 1'b1);
      v[i] = i_sda;
    end
    ph(1'b0, 1'b1); ph(1'b0, last); ph(1'b1, last); ph(1'b0, last);
    o_rd_byte <= v;
    o_rd_vld <= 1'b1;
  endtask
endmodule

// *** bench/test_dac_trim_calibration_config.sv ***
// Self-checking bench for the DAC trim and calibration config bank.
// Assumes the host model and checker compile first.
`timescale 1ns/100ps
module test_dac_trim_calibration_config;
  import dtc_pkg::*;
  // ==========================================================
  // Signals and instances
  // ==========================================================
  logic       clk, arst_n, scl, sda_h, sda, rvld, sdo, sda_oe_n, byp, full, avg, fdis, post;
  logic       drsv, dmid, dhi, dadj, dsgn, cms, ass, sd_off_n, short_detect_off_n, loc, shi, shg, lsc, rsc;
  logic [1:0] bond, shuf;
  logic [6:0] coarse;
  logic [5:0] fine;
  logic [7:0] rbyte;
  logic [7:0] exp_q[$];
  int         n_mismatch, checks, cyc;
  assign sda = sda_h & (sda_oe_n | sdo); // Pulled-up open drain
  dtc_trim_cfg dut (.i_sys_clk(clk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sdo),
    .o_sda_oe_n(sda_oe_n), .i_bond_sel(bond), .o_cal_filter_bypass(byp), .o_cal_filter_full_span(full),
    .o_cal_filter_averaging(avg), .o_cal_fine_disable(fdis), .o_cal_coarse_steps(coarse), .o_cal_fine_steps(fine),
    .o_cal_post_avg_disable(post), .o_dither_reserved_bond(drsv), .o_dither_bond_mid(dmid),
    .o_dither_bond_high(dhi), .o_dither_adjust(dadj), .o_secondary_dither_sign(dsgn), .o_clk_missing_speedup(cms),
    .o_analog_seq_speedup(ass), .o_short_detect_off_n(sd_off_n), .o_short_detect_en(short_detect_off_n),
    .o_later_offset_cancel_off(loc), .o_dwa_shuffle_sel(shuf), .o_dwa_shuffle_internal(shi),
    .o_dwa_shuffle_global(shg), .o_left_sec_scale(lsc), .o_right_sec_scale(rsc));
  dtc_i2c_host h (.i_sys_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_h), .o_rd_vld(rvld), .o_rd_byte(rbyte));
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic chk_out(input logic [7:0] r[7]);
    chk("cal", {3'h0, byp, full, avg, fdis, post}, {3'h0, r[0][4:0]});
    chk("coarse", {1'b0, coarse}, r[0][1] ? 8'd96 : 8'd64);
    chk("fine", {2'h0, fine}, r[0][1] ? 8'd0 : 8'd32);
    chk("dither", {4'h0, drsv, dmid, dhi, dadj}, {4'h0, r[0][7], r[1][7], r[2][7],
      bond == 2'h0 ? r[0][7] : bond == 2'h1 ? r[1][7] : bond == 2'h2 ? r[2][7] : 1'b0});
    chk("speedup", {6'h0, cms, ass}, {6'h0, r[3][4], r[3][0]});
    chk("short", {5'h0, sd_off_n, short_detect_off_n, loc}, {5'h0, r[4][4], !r[4][4], r[4][0]});
    chk("shuffle", {4'h0, shuf, shi, shg}, {4'h0, r[5][5:4], r[5][5:4] == 2'h1, r[5][5:4] == 2'h2});
    chk("scale", {5'h0, dsgn, lsc, rsc}, {5'h0, r[5][0], r[6][7], r[6][3]});
  endtask
  task automatic wr_regs(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d[$]);
    logic ok;
    h.start();
    h.wr({a, 1'b0}, ok);
    chk("addr ack", {7'h0, ok}, {7'h0, a == DTC_DEV_ADDR_DFLT});
    if (ok) begin
      h.wr(p, ok);
      foreach (d[i]) h.wr(d[i], ok);
    end
    h.stop();
  endtask
  task automatic rd_regs(input logic [7:0] p, input int n);
    logic ok;
    h.start();
    h.wr({DTC_DEV_ADDR_DFLT, 1'b0}, ok);
    h.wr(p, ok);
    h.rstart();
    h.wr({DTC_DEV_ADDR_DFLT, 1'b1}, ok);
    chk("rd addr ack", {7'h0, ok}, 8'h01);
    for (int i = 0; i < n; i++) h.rd(i == n - 1);
    h.stop();
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================================
  // Clock, monitor, timeout
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rvld === 1'b1)
      chk("read", rbyte, exp_q.size() > 0 ? exp_q.pop_front() : ~rbyte);
    if (cyc == 40000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    logic [7:0] img[7];
    logic [7:0] dft[7];
    logic [7:0] msk[7];
    logic [7:0] d[$];
    void'($urandom(62));
    msk = '{8'h9f, 8'h80, 8'h80, 8'h11, 8'h11, 8'h31, 8'h88};
    dft = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h20, 8'h00};
    img = dft;
    arst_n <= 1'b0;
    bond <= 2'h0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_out(img);
    wr_regs(DTC_DEV_ADDR_DFLT, 8'h00, {8'hfd});
    foreach (img[i]) exp_q.push_back(img[i]);
    rd_regs(8'h0b, 7);
    // Random images, every shuffle code and bond option
    for (int k = 0; k < 4; k++) begin
      d = {};
      for (int i = 0; i < 7; i++) begin
        img[i] = 8'($urandom()) & msk[i];
        if (i == 5) img[i][5:4] = 2'(k);
        d.push_back(img[i]);
      end
      bond <= 2'(k);
      wr_regs(DTC_DEV_ADDR_DFLT, 8'h0b, d);
      chk_out(img);
      foreach (img[i]) exp_q.push_back(img[i]);
      rd_regs(8'h0b, 7);
    end
    // Foreign address ignored, unmapped offset reads zero
    wr_regs(7'h15, 8'h11, {8'hff});
    exp_q.push_back(img[6]);
    exp_q.push_back(8'h00);
    rd_regs(8'h11, 2);
    // Reset in mid-run restores defaults
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_out(dft);
    // Page select back at its default, so the bank reads as zero
    exp_q.push_back(8'h00);
    rd_regs(8'h0f, 1);
    repeat (10) @(posedge clk);
    chk("pending", 8'(exp_q.size()), 8'h00);
    summarize();
  end
endmodule
